/* File: shared/bpcm_pkg.sv */
// Package of constants and types for the bridge power and clock manager
package bpcm_pkg;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_SYS_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_CARD_CTRL   = 8'h04;
   localparam logic [7:0] ADDR_SOCK_CTRL   = 8'h08;
   localparam logic [7:0] ADDR_STATUS      = 8'h0C;

   // ==========================================================
   // Field positions
   localparam int KEEP_PCI_CLOCK_BIT  = 1;
   localparam int RING_ROUTING_BIT    = 2;
   localparam int RING_MFUNC_SEL_BIT  = 3;
   localparam int MULTIFUNCTION_TERMINAL_6_CLKRUN_BIT   = 4;
   localparam int RING_OUT_EN_BIT     = 0;
   localparam int PME_EN_BIT          = 1;
   localparam int PME_STATUS_BIT      = 2;
   // Per socket byte in socket control register, socket s at 8*s
   localparam int SOCK_STRIDE         = 8;
   localparam int AUTO_POWER_DOWN_BIT = 0;
   localparam int STATUS_MASK_BIT     = 1;
   localparam int CARD_IS_CB_BIT      = 2;
   localparam int CARD_POWERED_BIT    = 3;
   localparam int RING_PATH_EN_BIT    = 7;
   localparam int CARD_OUT_DIS_BIT    = 6;

   localparam logic [31:0] SYS_CTRL_RESET  = 32'h0000_0010;
   localparam logic [31:0] CARD_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SOCK_CTRL_RESET = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS     = 5000;
   localparam int CLKRUN_WINDOW_NS  = 20;
   localparam int CLKRUN_WINDOW_CYC = (CLKRUN_WINDOW_NS * 1000) / CLK_PERIOD_PS;
   localparam int IDLE_NS           = 1000;
   localparam int IDLE_CYC          = (IDLE_NS * 1000) / CLK_PERIOD_PS;

   // ==========================================================
   // Grouped signals: engine busy flags and per socket inputs
   typedef struct packed {
      logic res16_busy;
      logic cb_master_busy;
      logic posted_data;
      logic irq_pending;
   } bpcm_busy_type;

   typedef struct packed {
      logic card_irq;
      logic status_event;
      logic cardbus_wake_request;
      logic ring_in;
      logic card_req;
      logic activity;
   } bpcm_sock_type;

   typedef enum logic [1:0] {
      CR_RUN,
      CR_HOLD,
      CR_STOPPED
   } bpcm_crun_type;

endpackage

/* File: hdl/bpcm_manager.sv */
// Power and clock manager of a PCI to PC Card bridge
`timescale 1ns/1ps

// Function
// RULE_01: Keep clock bit blocks PCI clock stop
// RULE_02: Busy engines or posted data block stop
// RULE_03: Pending interrupt or running card clock blocks
// RULE_04: Card interrupts request PCI clock restart
// RULE_05: Wake, status or ring events request restart
// RULE_06: Card clock start or bus request restart
// RULE_07: Clock run only on terminal 6 when configured
// RULE_08: Idle socket card clock stopped via clock run
// RULE_09: Output disable tristates and resets card
// RULE_10: Auto power down disables outputs when idle
// RULE_11: Suspend masks PCI and global resets
// RULE_12: Suspend tristates outputs, gates clock after transaction
// RULE_13: Host arbiter never parks during suspend
// RULE_14: Power switch clock never from PCI clock
// RULE_15: Async outputs need no clock, serial does
// RULE_16: GPIO, terminals, ring stay active in suspend
// RULE_17: Powered 16-bit ring drives ring out
// RULE_18: CardBus status change drives ring out
// RULE_19: Ring and PME need their enable bits
// RULE_20: Select zero shares terminal, ring wins
// RULE_21: Software using both selects separate terminal
// RULE_22: Reassert clock run within window when blocked
module bpcm_manager #(
   parameter int NUM_SOCK = 2,
   parameter int IDLE_COUNT = bpcm_pkg::IDLE_CYC
) (
   // Clock and reset
   input  wire logic                           sys_clk,
   input  wire logic                           rst,
   // AXI4-Lite slave
   input  wire logic [7:0]                     s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [7:0]                     s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   // PCI side
   input  wire logic                           pci_clk_in,
   input  wire logic                           pci_grant_n,
   input  wire logic                           pci_frame_n,
   input  wire logic                           pci_reset_in_n,
   input  wire logic                           global_reset_in_n,
   input  wire logic                           suspend_n,
   input  wire logic                           multifunction_terminal_6_in,
   output logic                                multifunction_terminal_6_out,
   output logic                                multifunction_terminal_6_oe,
   output logic                                pci_out_en,
   output logic                                pci_clk_gate,
   output logic                                pci_reset_int_n,
   output logic                                global_reset_int_n,
   output logic                                serial_irq_clk_need,
   // Internal engines
   input  wire bpcm_pkg::bpcm_busy_type        busy,
   // Sockets
   input  wire bpcm_pkg::bpcm_sock_type [1:0]  sock,
   input  wire logic [1:0]                     cclkrun_in,
   output logic [1:0]                          cclkrun_out,
   output logic [1:0]                          cclkrun_oe,
   output logic [1:0]                          card_clk_run,
   output logic [1:0]                          card_if_tristate,
   output logic [1:0]                          card_reset,
   // Wake outputs and power switch clock select
   output logic                                ring_pme_n,
   output logic                                multifunction_terminal_2_n,
   output logic                                multifunction_terminal_4_n,
   output logic                                power_switch_clk_sel
);
   import bpcm_pkg::*;

   // ==========================================================
   // Input synchronisers (three stages, change when 2 and 3 agree)
   localparam int NSYNC = 7;
   localparam int SYNC_LAG = 4;
   // Idle levels; host clock run idles low while the clock runs
   localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h7E;
   logic rst_eff;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sy1, sy2, sy3, filt, next_filt;
   assign raw_in = {cclkrun_in, pci_clk_in, pci_grant_n, pci_frame_n,
                    suspend_n, multifunction_terminal_6_in};

   always_comb begin
      for (int i = 0; i < NSYNC; i++) begin
         next_filt[i] = (sy2[i] == sy3[i]) ? sy3[i] : filt[i];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst_eff) begin
         sy1  <= SYNC_IDLE;
         sy2  <= SYNC_IDLE;
         sy3  <= SYNC_IDLE;
         filt <= SYNC_IDLE;
      end else begin
         sy1  <= raw_in;
         sy2  <= sy1;
         sy3  <= sy2;
         filt <= next_filt;
      end
   end

   logic       crun_s, susp_s, frame_s, grant_s, pclk_s;
   logic [1:0] cclkrun_s;
   assign crun_s    = filt[0];
   assign susp_s    = ~filt[1];
   assign frame_s   = ~filt[2];
   assign grant_s   = ~filt[3];
   assign pclk_s    = filt[4];
   assign cclkrun_s = filt[6:5];

   // ==========================================================
   // Registers
   logic [31:0] sys_ctrl, card_ctrl, sock_ctrl;
   logic [31:0] next_sys_ctrl, next_card_ctrl, next_sock_ctrl;
   logic        aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0]  awaddr_q, next_awaddr_q;
   logic [31:0] wdata_q, next_wdata_q;
   logic [3:0]  wstrb_q, next_wstrb_q;
   logic        bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0]  bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata, status_word;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[b*8 +: 8] = d[b*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return a == ADDR_SYS_CTRL || a == ADDR_CARD_CTRL ||
             a == ADDR_SOCK_CTRL || a == ADDR_STATUS;
   endfunction

   assign s_axi_awready = ~aw_held & ~bvalid;
   assign s_axi_wready  = ~w_held & ~bvalid;
   assign s_axi_arready = ~rvalid;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rresp   = rresp;
   assign s_axi_rdata   = rdata;

   logic    pme_status, next_pme_status;

   always_comb begin
      logic       have_aw, have_w;
      logic [7:0] a;
      logic [31:0] d;
      logic [3:0] be;
      have_aw = 1'b0;
      have_w  = 1'b0;
      a  = awaddr_q;
      d  = wdata_q;
      be = wstrb_q;
      next_sys_ctrl  = sys_ctrl;
      next_card_ctrl = card_ctrl;
      next_sock_ctrl = sock_ctrl;
      next_aw_held   = aw_held;
      next_w_held    = w_held;
      next_awaddr_q  = awaddr_q;
      next_wdata_q   = wdata_q;
      next_wstrb_q   = wstrb_q;
      next_bvalid    = bvalid;
      next_bresp     = bresp;
      next_rvalid    = rvalid;
      next_rresp     = rresp;
      next_rdata     = rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         a = s_axi_awaddr;
         next_awaddr_q = s_axi_awaddr;
         next_aw_held = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d = s_axi_wdata;
         be = s_axi_wstrb;
         next_wdata_q = s_axi_wdata;
         next_wstrb_q = s_axi_wstrb;
         next_w_held = 1'b1;
      end
      have_aw = next_aw_held;
      have_w  = next_w_held;
      if (have_aw && have_w && !bvalid) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = mapped(a) ? RESP_OKAY : RESP_SLVERR;
         case (a)
            ADDR_SYS_CTRL:  next_sys_ctrl  = merge(sys_ctrl, d, be);
            ADDR_CARD_CTRL: next_card_ctrl = merge(card_ctrl, d, be);
            ADDR_SOCK_CTRL: next_sock_ctrl = merge(sock_ctrl, d, be);
            default: ;
         endcase
      end
      if (bvalid && s_axi_bready) next_bvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_SYS_CTRL:  next_rdata = sys_ctrl;
            ADDR_CARD_CTRL: next_rdata = card_ctrl;
            ADDR_SOCK_CTRL: next_rdata = sock_ctrl;
            ADDR_STATUS:    next_rdata = status_word;
            default:        next_rdata = 32'h0000_0000;
         endcase
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   // Suspend masks both resets so register contents survive
   assign rst_eff = rst & ~susp_s; // RULE_11

   always_ff @(posedge sys_clk) begin
      if (rst_eff) begin
         sys_ctrl  <= SYS_CTRL_RESET;
         card_ctrl <= CARD_CTRL_RESET;
         sock_ctrl <= SOCK_CTRL_RESET;
      end else begin
         sys_ctrl  <= next_sys_ctrl;
         card_ctrl <= next_card_ctrl;
         sock_ctrl <= next_sock_ctrl;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_held  <= 1'b0;
         w_held   <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         bvalid   <= 1'b0;
         bresp    <= RESP_OKAY;
         rvalid   <= 1'b0;
         rresp    <= RESP_OKAY;
         rdata    <= 32'h0000_0000;
      end else begin
         aw_held  <= next_aw_held;
         w_held   <= next_w_held;
         awaddr_q <= next_awaddr_q;
         wdata_q  <= next_wdata_q;
         wstrb_q  <= next_wstrb_q;
         bvalid   <= next_bvalid;
         bresp    <= next_bresp;
         rvalid   <= next_rvalid;
         rresp    <= next_rresp;
         rdata    <= next_rdata;
      end
   end

   // ==========================================================
   // Card clock manager and 16-bit power down per socket
   logic [1:0] cclk_run, next_cclk_run, restart_ev, ring_ev, wake_ev, cb_sock;
   logic [15:0] idle_cnt [1:0];
   logic [15:0] next_idle_cnt [1:0];

   for (genvar s = 0; s < 2; s++) begin : g_sock
      logic apd, smask, is_cb, pwr, ring_path_enable, card_output_disable, idle, card_start;
      logic [SYNC_LAG-1:0] own_hist, next_own_hist;
      assign apd    = sock_ctrl[s*SOCK_STRIDE + AUTO_POWER_DOWN_BIT];
      assign smask  = sock_ctrl[s*SOCK_STRIDE + STATUS_MASK_BIT];
      assign is_cb  = sock_ctrl[s*SOCK_STRIDE + CARD_IS_CB_BIT];
      assign pwr    = sock_ctrl[s*SOCK_STRIDE + CARD_POWERED_BIT];
      assign card_output_disable    = sock_ctrl[s*SOCK_STRIDE + CARD_OUT_DIS_BIT];
      assign ring_path_enable = sock_ctrl[s*SOCK_STRIDE + RING_PATH_EN_BIT];
      assign idle   = idle_cnt[s] >= 16'(IDLE_COUNT);
      assign cb_sock[s] = is_cb;
      // Our own drive echoes back late; not a card start
      assign card_start = ~cclkrun_s[s] & ~(|own_hist);
      always_comb begin
         next_idle_cnt[s] = sock[s].activity ? 16'h0000 :
                            (idle ? idle_cnt[s] : idle_cnt[s] + 16'h0001);
         next_own_hist    = {own_hist[SYNC_LAG-2:0], cclkrun_oe[s]};
         next_cclk_run[s] = cclk_run[s];
         // Card start via clock run low or bus request restarts clock
         if (card_start || sock[s].card_req || sock[s].activity)
            next_cclk_run[s] = 1'b1; // RULE_06
         else if (idle && is_cb)
            next_cclk_run[s] = 1'b0; // RULE_08
      end
      always_ff @(posedge sys_clk) begin
         if (rst_eff) own_hist <= '0;
         else         own_hist <= next_own_hist;
      end
      // Output disable resets a 16-bit card; auto power down does not
      assign card_if_tristate[s] = card_output_disable | (apd & idle & ~is_cb); // RULE_09 RULE_10
      assign card_reset[s]       = card_output_disable & ~is_cb; // RULE_09
      // We signal clock stop to the card by our release of its clock run line
      assign cclkrun_out[s] = 1'b0;
      assign cclkrun_oe[s]  = cclk_run[s] & is_cb; // RULE_08
      assign ring_ev[s] = (sock[s].ring_in & ring_path_enable & pwr & ~is_cb) // RULE_17
                        | ((sock[s].cardbus_wake_request | sock[s].status_event)
                           & smask & is_cb); // RULE_18
      assign wake_ev[s] = sock[s].cardbus_wake_request | sock[s].status_event |
                          sock[s].ring_in;
      assign restart_ev[s] = sock[s].card_irq | wake_ev[s] | // RULE_04 RULE_05
                             sock[s].card_req | (is_cb & card_start); // RULE_06
   end

   always_ff @(posedge sys_clk) begin
      if (rst_eff) begin
         cclk_run <= 2'b11;
         idle_cnt[0] <= 16'h0000;
         idle_cnt[1] <= 16'h0000;
      end else begin
         cclk_run <= next_cclk_run;
         idle_cnt[0] <= next_idle_cnt[0];
         idle_cnt[1] <= next_idle_cnt[1];
      end
   end
   assign card_clk_run = cclk_run;

   // ==========================================================
   // PCI clock run on terminal 6
   logic block_stop;
   assign block_stop = sys_ctrl[KEEP_PCI_CLOCK_BIT] // RULE_01
                     | busy.res16_busy | busy.cb_master_busy | busy.posted_data // RULE_02
                     | busy.irq_pending | (|(cclk_run & cb_sock)); // RULE_03

   bpcm_crun_type state, next_state;
   logic [7:0] win_cnt, next_win_cnt;
   logic       crun_en;
   assign crun_en = sys_ctrl[MULTIFUNCTION_TERMINAL_6_CLKRUN_BIT]; // RULE_07

   // Only a short pulse is driven: the line is shared with the host
   always_comb begin
      next_state   = state;
      next_win_cnt = win_cnt;
      case (state)
         CR_RUN: begin
            if (crun_en && crun_s) begin
               if (block_stop) begin
                  next_state   = CR_HOLD;
                  next_win_cnt = 8'(CLKRUN_WINDOW_CYC);
               end else begin
                  next_state = CR_STOPPED;
               end
            end
         end
         CR_HOLD: begin
            if (win_cnt == 8'h01) next_state = CR_RUN;
            next_win_cnt = win_cnt - 8'h01;
         end
         CR_STOPPED: begin
            if (!crun_s) next_state = CR_RUN;
            else if (|restart_ev) begin
               next_state   = CR_HOLD;
               next_win_cnt = 8'(CLKRUN_WINDOW_CYC);
            end
         end
         default: next_state = CR_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst_eff) begin
         state   <= CR_RUN;
         win_cnt <= 8'h00;
      end else begin
         state   <= next_state;
         win_cnt <= next_win_cnt;
      end
   end
   assign multifunction_terminal_6_out = 1'b0;
   assign multifunction_terminal_6_oe  = crun_en && state == CR_HOLD; // RULE_22 RULE_04 RULE_07

   // ==========================================================
   // Suspend gating; arbiter must not park on us meanwhile
   logic gated, next_gated;
   always_comb begin
      next_gated = gated;
      if (!susp_s) next_gated = 1'b0;
      else if (!(grant_s && frame_s)) next_gated = 1'b1; // RULE_12 RULE_13
   end
   always_ff @(posedge sys_clk) begin
      if (rst) gated <= 1'b0;
      else     gated <= next_gated;
   end
   assign pci_clk_gate       = gated; // RULE_12
   assign pci_out_en         = ~susp_s; // RULE_12
   assign pci_reset_int_n    = pci_reset_in_n | susp_s; // RULE_11
   assign global_reset_int_n = global_reset_in_n | susp_s; // RULE_11
   assign power_switch_clk_sel = 1'b1; // RULE_14
   assign serial_irq_clk_need  = |restart_ev; // RULE_15

   // ==========================================================
   // Ring and PME routing, live through suspend
   logic ring_on, pme_on, ring_act;
   assign ring_on  = card_ctrl[RING_OUT_EN_BIT] & (|ring_ev); // RULE_19 RULE_16
   assign pme_on   = card_ctrl[PME_EN_BIT] & pme_status; // RULE_19
   assign ring_act = ring_on;
   always_comb begin
      next_pme_status = pme_status | (|wake_ev);
      if (bvalid && awaddr_q == ADDR_CARD_CTRL && wdata_q[PME_STATUS_BIT] && !(|wake_ev))
         next_pme_status = 1'b0;
   end
   always_ff @(posedge sys_clk) begin
      if (rst_eff) pme_status <= 1'b0;
      else         pme_status <= next_pme_status;
   end
   // Shared terminal: ring enable hides PME entirely when select is 0
   always_comb begin
      ring_pme_n = 1'b1;
      multifunction_terminal_2_n = 1'b1;
      multifunction_terminal_4_n = 1'b1;
      if (!sys_ctrl[RING_ROUTING_BIT]) begin
         if (card_ctrl[RING_OUT_EN_BIT]) ring_pme_n = ~ring_act; // RULE_20
         else ring_pme_n = ~pme_on;
      end else begin
         ring_pme_n = ~pme_on; // RULE_21
         if (sys_ctrl[RING_MFUNC_SEL_BIT]) multifunction_terminal_4_n = ~ring_act;
         else multifunction_terminal_2_n = ~ring_act;
      end
   end
   assign status_word = {24'h000000, pme_status, gated, state == CR_STOPPED, 3'b000, cclk_run};

   // ==========================================================
   // Assertions
   a_keep_clk_blocks: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
      (state == CR_RUN && crun_en && crun_s && sys_ctrl[KEEP_PCI_CLOCK_BIT])
      |=> state == CR_HOLD) else $error("keep bit did not hold clock");
   a_busy_blocks: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
      (state == CR_RUN && crun_en && crun_s && busy.posted_data)
      |=> state != CR_STOPPED) else $error("stop while busy");
   a_irq_blocks: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
      (state == CR_RUN && crun_en && crun_s && busy.irq_pending)
      |=> multifunction_terminal_6_oe) else $error("stop while irq pending");
   a_restart_req: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
      (state == CR_STOPPED && crun_s && crun_en && |restart_ev) |=> multifunction_terminal_6_oe)
      else $error("no restart request");
   a_coe_reset: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
      card_reset[0] |-> card_if_tristate[0]) else $error("reset without tristate");
   a_suspend_tri: assert property (@(posedge sys_clk) disable iff (rst) // RULE_12
      susp_s |-> !pci_out_en) else $error("outputs on in suspend");
   a_gate_waits: assert property (@(posedge sys_clk) disable iff (rst) // RULE_12
      (susp_s && grant_s && frame_s && !gated) |=> !gated)
      else $error("gated during transaction");
   a_hold_window: assert property (@(posedge sys_clk) disable iff (rst) // RULE_22
      $rose(multifunction_terminal_6_oe) |-> multifunction_terminal_6_oe [*2]) else $error("short clock run pulse");
endmodule // bpcm_manager

/* File: test/bpcm_host_model.sv */
// Host central clock resource model
`timescale 1ns/1ps
module bpcm_host_model (
   // Clock and control
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic stop_req,
   input  wire logic suspend_n,
   // Clock run line
   input  wire logic dev_oe,
   output logic      clkrun_in,
   output logic      kept,
   // PCI bus
   output logic      pci_clk_in,
   output logic      pci_grant_n,
   output logic      pci_frame_n
);
   logic host_drv;
   // ==========================================
   // Pulled up line, low while anyone drives
   assign clkrun_in = !(host_drv || dev_oe);
   // Grant withdrawn in suspend, never parked there
   assign pci_grant_n = !suspend_n;
   assign pci_frame_n = 1'b1;
   // Clock stands still once stopped
   initial begin
      pci_clk_in = 1'b0;
      forever #32 if (host_drv) pci_clk_in = ~pci_clk_in;
   end
   always_ff @(posedge sys_clk) begin
      if (rst || !stop_req) begin
         host_drv <= 1'b1;
         kept     <= 1'b0;
      end else if (dev_oe) begin
         host_drv <= 1'b1;
         kept     <= 1'b1;
      end else if (!kept) begin
         host_drv <= 1'b0;
      end
   end
endmodule // bpcm_host_model

/* File: test/bpcm_manager_tb_top.sv */
// Testbench for the bridge power and clock manager
`timescale 1ns/1ps
module bpcm_manager_tb_top;
   import bpcm_pkg::*;
   logic sys_clk, rst, stop_req, kept, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, pci_clk_in, pci_grant_n, pci_frame_n;
   logic pci_reset_in_n, global_reset_in_n, suspend_n, multifunction_terminal_6_in, multifunction_terminal_6_out;
   logic multifunction_terminal_6_oe, pci_out_en, pci_clk_gate, pci_reset_int_n, global_reset_int_n;
   logic serial_irq_clk_need, ring_pme_n, power_switch_clk_sel;
   logic multifunction_terminal_2_n, multifunction_terminal_4_n;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr, cclkrun_in, cclkrun_out, cclkrun_oe;
   logic [1:0] card_clk_run, card_if_tristate, card_reset;
   bpcm_busy_type busy;
   bpcm_sock_type [1:0] sock;
   int err_count, n_compared, cyc;
   // Rows: keep bit, busy, socket event, clock kept
   logic [11:0] rows [11] = '{12'h801, 12'h401, 12'h201, 12'h101, 12'h081,
      12'h000, 12'h041, 12'h021, 12'h011, 12'h009, 12'h005};
   // Cards never hold the pulled up line
   assign cclkrun_in = ~cclkrun_oe;
   bpcm_manager #(.IDLE_COUNT(8)) u_dut (.*);
   bpcm_host_model u_host (.sys_clk(sys_clk), .rst(rst), .stop_req(stop_req),
      .suspend_n(suspend_n), .dev_oe(multifunction_terminal_6_oe), .clkrun_in(multifunction_terminal_6_in), .kept(kept),
      .pci_clk_in(pci_clk_in), .pci_grant_n(pci_grant_n), .pci_frame_n(pci_frame_n));
   // ==========================================
   // Tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================
   // Clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         summarize();
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      {rst, pci_reset_in_n, global_reset_in_n, suspend_n} = 4'hF;
      {stop_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      busy = '0;
      sock = '0;
      {err_count, n_compared} = '0;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (40) @(posedge sys_clk);
      rdr(ADDR_SYS_CTRL);
      chk("sys_ctrl", SYS_CTRL_RESET, rd);
      chk("card clocks", 3, card_clk_run);
      chk("switch clock", 1, power_switch_clk_sel);
      rdr(8'h10);
      chk("unmapped", RESP_SLVERR, rr);
      foreach (rows[i]) begin
         if (rows[i][11]) wr(ADDR_SYS_CTRL, 32'h12);
         busy <= bpcm_busy_type'(rows[i][10:7]);
         repeat (12) @(posedge sys_clk);
         stop_req <= 1'b1;
         repeat (20) @(posedge sys_clk);
         sock[1] <= bpcm_sock_type'(rows[i][6:1]);
         repeat (20) @(posedge sys_clk);
         chk("kept", rows[i][0], kept);
         sock <= '0;
         busy <= '0;
         stop_req <= 1'b0;
         wr(ADDR_SYS_CTRL, SYS_CTRL_RESET);
         repeat (20) @(posedge sys_clk);
      end
      wr(ADDR_SOCK_CTRL, 32'h04);
      repeat (20) @(posedge sys_clk);
      chk("idle card clock", 2, card_clk_run);
      sock[0].card_req <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("card clock start", 3, card_clk_run);
      sock <= '0;
      wr(ADDR_CARD_CTRL, 32'h1);
      wr(ADDR_SOCK_CTRL, 32'h88);
      sock[0].ring_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("ring", 0, ring_pme_n);
      wr(ADDR_SYS_CTRL, 32'h14);
      wr(ADDR_CARD_CTRL, 32'h3);
      repeat (3) @(posedge sys_clk);
      chk("ring and pme", 0, {ring_pme_n, multifunction_terminal_2_n});
      wr(ADDR_SOCK_CTRL, 32'h08);
      repeat (3) @(posedge sys_clk);
      chk("ring masked", 1, multifunction_terminal_2_n);
      sock <= '0;
      wr(ADDR_SOCK_CTRL, 32'h40);
      repeat (3) @(posedge sys_clk);
      chk("disable", 3, {card_if_tristate[0], card_reset[0]});
      wr(ADDR_SOCK_CTRL, 32'h01);
      repeat (20) @(posedge sys_clk);
      chk("power down", 2, {card_if_tristate[0], card_reset[0]});
      {pci_reset_in_n, global_reset_in_n, suspend_n} <= 3'h0;
      repeat (10) @(posedge sys_clk);
      chk("reset gate", 3, {pci_reset_int_n, global_reset_int_n});
      chk("pci out", 1, {pci_out_en, pci_clk_gate});
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rdr(ADDR_SOCK_CTRL);
      chk("kept reg", 1, rd);
      summarize();
   end
endmodule // bpcm_manager_tb_top
